// *** design/charger_regs_pkg.sv ***
// charger control and status register group: constants, codes and carrier types
// assumes a 200 MHz core clock and a byte-wide register access port from the serial engine
//
// Contract
// - writing 1 to force_input_limit_detect starts detection; hardware clears it when done
// - half_rate_safety_timer set halves safety timer rate during dpm, cool or thermal loop
// - battery_switch_off set turns the switch off, after ship_mode_delay if delayed
// - battery_switch_off_delay: 0 immediate turn-off, 1 turn-off after ship_mode_delay
// - warm zone: select 0 clamps charge voltage to min of 4.1V and target
// - battery_switch_reset_enable 1 permits the switch reset function, 0 disables it
// - discharge_overcurrent_filter picks deglitch 128us, 256us, 1ms or 2ms
// - control resets to 0x4C; switch off, switch delay and filter fields ignore watchdog expiry
// - detecting variant reports none, SDP, CDP, DCP, unknown, non-standard or OTG
// - base variant reports 001 SDP with select pin high, 010 adaptor when low
// - charge_phase reports disabled, pre-charge, fast charge or terminated
// - input_power_good reads 1 while input supply is good and not weak
// - thermal_regulation_flag reads 1 while charge is reduced for thermal regulation
// - min_system_regulation_flag reads 1 while system voltage is regulated at minimum
// - watchdog expired flag reads 1 after the watchdog timer ran out
// - otg fault flag reads 1 while any condition prevents boost operation
// - charge_fault_code reports normal, input fault, thermal shutdown or timer expiry
// - temperature_zone_code follows the live zone, no read needed to clear
// - watchdog period disabled, 40s, 80s or 160s; expiry restores marked fields
package charger_regs_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h07;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] FAULT_OFFSET = 8'h09;
   localparam logic [7:0] CTRL_RESET = 8'h4C;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHIP_DELAY_MS = 12000;
   localparam int SHIP_DELAY_TICKS = SHIP_DELAY_MS;
   localparam int OCP_T0_NS = 128000;
   localparam int OCP_T1_NS = 256000;
   localparam int OCP_T2_NS = 1000000;
   localparam int OCP_T3_NS = 2000000;
   localparam int OCP_T0_CYCLES = (OCP_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OCP_T1_CYCLES = (OCP_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OCP_T2_CYCLES = (OCP_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OCP_T3_CYCLES = (OCP_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WD_40S_S = 40;
   localparam int WD_80S_S = 80;
   localparam int WD_160S_S = 160;
   localparam int WD_40S_TICKS = WD_40S_S * 1000;
   localparam int WD_80S_TICKS = WD_80S_S * 1000;
   localparam int WD_160S_TICKS = WD_160S_S * 1000;
   localparam int CNT_W = 20;

   // ----------------------------------------
   // codes
   // ----------------------------------------
   localparam logic [1:0] WD_OFF = 2'h0;
   localparam logic [1:0] WD_40S = 2'h1;
   localparam logic [1:0] WD_80S = 2'h2;
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_SDP = 3'h1;
   localparam logic [2:0] SRC_ADAPTOR = 3'h2;
   localparam logic [2:0] SRC_OTG = 3'h7;
   localparam logic [2:0] ZONE_WARM = 3'h2;
   localparam logic [2:0] ZONE_COOL = 3'h3;

   typedef enum logic [1:0] {
      SW_ON = 2'h0,
      SW_WAIT = 2'h1,
      SW_OFF = 2'h3
   } switch_state_e;

   // ----------------------------------------
   // register layouts, msb first
   // ----------------------------------------
   typedef struct packed {
      logic forceDetect;
      logic halfRate;
      logic switchOff;
      logic warmVoltSel;
      logic switchDelay;
      logic switchRstEn;
      logic [1:0] ocpFilter;
   } ctrl_s;

   typedef struct packed {
      logic [2:0] sourceType;
      logic [1:0] chargePhase;
      logic powerGood;
      logic thermReg;
      logic minSysReg;
   } status_s;

   typedef struct packed {
      logic wdFault;
      logic otgFault;
      logic [1:0] chargeFault;
      logic batFault;
      logic [2:0] tempZone;
   } fault_s;

endpackage

// *** design/ocp_deglitch.sv ***
// discharge overcurrent deglitch filter with four selectable windows
// assumes the comparator input is already synchronised to core_clk
`timescale 1ns/1ps
module ocp_deglitch #(
   parameter int T0_CYCLES = charger_regs_pkg::OCP_T0_CYCLES,
   parameter int T1_CYCLES = charger_regs_pkg::OCP_T1_CYCLES,
   parameter int T2_CYCLES = charger_regs_pkg::OCP_T2_CYCLES,
   parameter int T3_CYCLES = charger_regs_pkg::OCP_T3_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [1:0] filterSel,
   input wire logic rawOver,
   output logic tripped
);
   typedef struct packed {
      logic [charger_regs_pkg::CNT_W-1:0] cnt;
      logic trip;
   } filt_s;

   filt_s st_r;
   filt_s st_nxt;
   logic [charger_regs_pkg::CNT_W-1:0] limit;

   // ----------------------------------------
   // filter
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      unique case (filterSel)
         2'h0: limit = charger_regs_pkg::CNT_W'(T0_CYCLES - 1);
         2'h1: limit = charger_regs_pkg::CNT_W'(T1_CYCLES - 1);
         2'h2: limit = charger_regs_pkg::CNT_W'(T2_CYCLES - 1);
         2'h3: limit = charger_regs_pkg::CNT_W'(T3_CYCLES - 1);
      endcase
      // any low sample restarts the window, so short spikes never trip
      if (!rawOver) begin
         st_nxt.cnt = '0;
         st_nxt.trip = 1'b0;
      end else if (st_r.cnt >= limit) begin
         st_nxt.trip = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tripped = st_r.trip;

   a_ocp_trip_held: assert property (@(posedge core_clk) disable iff (sys_rst)
      !st_r.trip ##1 st_r.trip |-> $past(rawOver) && $past(st_r.cnt) >= $past(limit))
      else $error("overcurrent trip without a full window");
endmodule

// *** design/charger_control_status_regs.sv ***
// charger control register and the two read-only status and fault registers
// assumes a byte register port from the serial engine and live status from the charger core
`timescale 1ns/1ps
module charger_control_status_regs #(
   parameter bit BASE_VARIANT = 1'b0,
   parameter int TICK_CYCLES = charger_regs_pkg::TICK_CYCLES,
   parameter int SHIP_DELAY_TICKS = charger_regs_pkg::SHIP_DELAY_TICKS,
   parameter int OCP_T0_CYCLES = charger_regs_pkg::OCP_T0_CYCLES,
   parameter int OCP_T1_CYCLES = charger_regs_pkg::OCP_T1_CYCLES,
   parameter int OCP_T2_CYCLES = charger_regs_pkg::OCP_T2_CYCLES,
   parameter int OCP_T3_CYCLES = charger_regs_pkg::OCP_T3_CYCLES,
   parameter int WD_40S_TICKS = charger_regs_pkg::WD_40S_TICKS,
   parameter int WD_80S_TICKS = charger_regs_pkg::WD_80S_TICKS,
   parameter int WD_160S_TICKS = charger_regs_pkg::WD_160S_TICKS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic regDefaultsRestore,
   input wire logic watchdogKick,
   input wire logic [1:0] watchdogPeriodSel,
   input wire logic vbusPresent,
   input wire logic inputDetectDone,
   input wire logic dpmActive,
   input wire logic thermRegActive,
   input wire logic sourceSelectPin,
   input wire logic [2:0] detectedSourceType,
   input wire logic otgActive,
   input wire logic [1:0] chargePhaseIn,
   input wire logic powerGoodIn,
   input wire logic minSysRegIn,
   input wire logic otgFaultIn,
   input wire logic [1:0] chargeFaultIn,
   input wire logic batFaultIn,
   input wire logic [2:0] tempZoneIn,
   input wire logic overcurrentPin,
   output logic inputDetectReq,
   output logic safetyTimerTick,
   output logic batterySwitchOn,
   output logic warmVoltageClamp,
   output logic switchResetEnable,
   output logic [1:0] overcurrentFilterSel,
   output logic overcurrentTrip,
   output logic watchdogExpired
);
   localparam int CW = charger_regs_pkg::CNT_W;

   typedef struct packed {
      charger_regs_pkg::ctrl_s ctrl;
      charger_regs_pkg::status_s status;
      charger_regs_pkg::fault_s fault;
      logic [7:0] rdData;
      logic [CW-1:0] tickCnt;
      logic tick;
      logic halfPhase;
      logic safetyTick;
      logic [CW-1:0] wdCnt;
      charger_regs_pkg::switch_state_e swState;
      logic [CW-1:0] swCnt;
      logic clamp;
      logic [1:0] pselSync;
      logic [1:0] ocpSync;
   } state_s;

   localparam state_s STATE_RESET = '{
      ctrl: charger_regs_pkg::CTRL_RESET,
      status: '0,
      fault: '0,
      rdData: '0,
      tickCnt: '0,
      tick: 1'b0,
      halfPhase: 1'b0,
      safetyTick: 1'b0,
      wdCnt: '0,
      swState: charger_regs_pkg::SW_ON,
      swCnt: '0,
      clamp: 1'b0,
      pselSync: '0,
      ocpSync: '0
   };

   state_s st_r;
   state_s st_nxt;
   charger_regs_pkg::ctrl_s ctrlDefault;
   logic ctrlWrite;
   logic slowTimer;
   logic wdExpire;
   logic [CW-1:0] wdLimit;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      ctrlDefault = charger_regs_pkg::CTRL_RESET;
      ctrlWrite = regWrEn && (regAddr == charger_regs_pkg::CTRL_OFFSET);

      // two-flop synchronisers for the pins
      st_nxt.pselSync = {st_r.pselSync[0], sourceSelectPin};
      st_nxt.ocpSync = {st_r.ocpSync[0], overcurrentPin};

      // millisecond time base shared by watchdog, ship delay and safety timer
      st_nxt.tick = 1'b0;
      if (st_r.tickCnt >= CW'(TICK_CYCLES - 1)) begin
         st_nxt.tickCnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tickCnt = st_r.tickCnt + 1'b1;
      end

      // watchdog
      // periods are parameters so that a short expiry can be reached in simulation
      unique case (watchdogPeriodSel)
         charger_regs_pkg::WD_OFF: wdLimit = '0;
         charger_regs_pkg::WD_40S: wdLimit = CW'(WD_40S_TICKS - 1);
         charger_regs_pkg::WD_80S: wdLimit = CW'(WD_80S_TICKS - 1);
         default: wdLimit = CW'(WD_160S_TICKS - 1);
      endcase
      wdExpire = 1'b0;
      if (watchdogPeriodSel == charger_regs_pkg::WD_OFF || watchdogKick || regDefaultsRestore) begin
         st_nxt.wdCnt = '0;
      end else if (st_r.tick) begin
         if (st_r.wdCnt >= wdLimit) begin
            wdExpire = 1'b1;
            st_nxt.wdCnt = '0;
         end else begin
            st_nxt.wdCnt = st_r.wdCnt + 1'b1;
         end
      end

      // control register: hardware clear first, so a host write of 1 wins
      if (inputDetectDone) begin
         st_nxt.ctrl.forceDetect = 1'b0;
      end
      if (ctrlWrite) begin
         st_nxt.ctrl = charger_regs_pkg::ctrl_s'(regWrData);
      end
      // expiry spares the switch off, switch delay and filter fields
      if (wdExpire) begin
         st_nxt.ctrl.forceDetect = ctrlDefault.forceDetect;
         st_nxt.ctrl.halfRate = ctrlDefault.halfRate;
         st_nxt.ctrl.warmVoltSel = ctrlDefault.warmVoltSel;
         st_nxt.ctrl.switchRstEn = ctrlDefault.switchRstEn;
      end
      if (regDefaultsRestore) begin
         st_nxt.ctrl = ctrlDefault;
      end

      // live status; nothing in the write path reaches these fields
      if (BASE_VARIANT) begin
         if (otgActive) begin
            st_nxt.status.sourceType = charger_regs_pkg::SRC_OTG;
         end else if (!vbusPresent) begin
            st_nxt.status.sourceType = charger_regs_pkg::SRC_NONE;
         end else if (st_r.pselSync[1]) begin
            st_nxt.status.sourceType = charger_regs_pkg::SRC_SDP;
         end else begin
            st_nxt.status.sourceType = charger_regs_pkg::SRC_ADAPTOR;
         end
      end else begin
         st_nxt.status.sourceType = detectedSourceType;
      end
      st_nxt.status.chargePhase = chargePhaseIn;
      st_nxt.status.powerGood = powerGoodIn;
      st_nxt.status.thermReg = thermRegActive;
      st_nxt.status.minSysReg = minSysRegIn;

      // watchdog flag: a kick in the same cycle blocks the expiry, so the kick wins
      if (watchdogKick || regDefaultsRestore) begin
         st_nxt.fault.wdFault = 1'b0;
      end
      if (wdExpire) begin
         st_nxt.fault.wdFault = 1'b1;
      end
      st_nxt.fault.otgFault = otgFaultIn;
      st_nxt.fault.chargeFault = chargeFaultIn;
      st_nxt.fault.batFault = batFaultIn;
      st_nxt.fault.tempZone = tempZoneIn;

      // safety timer rate
      slowTimer = st_r.ctrl.halfRate && (dpmActive || thermRegActive
         || st_r.fault.tempZone == charger_regs_pkg::ZONE_COOL);
      st_nxt.safetyTick = 1'b0;
      if (st_r.tick) begin
         if (slowTimer) begin
            st_nxt.halfPhase = !st_r.halfPhase;
            st_nxt.safetyTick = st_r.halfPhase;
         end else begin
            st_nxt.halfPhase = 1'b0;
            st_nxt.safetyTick = 1'b1;
         end
      end

      // warm zone voltage clamp
      st_nxt.clamp = (st_r.fault.tempZone == charger_regs_pkg::ZONE_WARM)
         && !st_r.ctrl.warmVoltSel;

      // battery switch
      unique case (st_r.swState)
         charger_regs_pkg::SW_ON: begin
            st_nxt.swCnt = '0;
            if (st_r.ctrl.switchOff) begin
               st_nxt.swState = st_r.ctrl.switchDelay ? charger_regs_pkg::SW_WAIT
                  : charger_regs_pkg::SW_OFF;
            end
         end
         charger_regs_pkg::SW_WAIT: begin
            if (!st_r.ctrl.switchOff) begin
               st_nxt.swState = charger_regs_pkg::SW_ON;
            end else if (!st_r.ctrl.switchDelay) begin
               st_nxt.swState = charger_regs_pkg::SW_OFF;
            end else if (st_r.tick) begin
               if (st_r.swCnt >= CW'(SHIP_DELAY_TICKS - 1)) begin
                  st_nxt.swState = charger_regs_pkg::SW_OFF;
               end else begin
                  st_nxt.swCnt = st_r.swCnt + 1'b1;
               end
            end
         end
         charger_regs_pkg::SW_OFF: begin
            if (!st_r.ctrl.switchOff) begin
               st_nxt.swState = charger_regs_pkg::SW_ON;
            end
         end
         default: st_nxt.swState = charger_regs_pkg::SW_ON;
      endcase

      // read port; writes to the read-only offsets fall through untouched
      if (regRdEn) begin
         unique case (regAddr)
            charger_regs_pkg::CTRL_OFFSET: st_nxt.rdData = st_r.ctrl;
            charger_regs_pkg::STATUS_OFFSET: st_nxt.rdData = st_r.status;
            charger_regs_pkg::FAULT_OFFSET: st_nxt.rdData = st_r.fault;
            default: st_nxt.rdData = charger_regs_pkg::UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   ocp_deglitch #(
      .T0_CYCLES(OCP_T0_CYCLES),
      .T1_CYCLES(OCP_T1_CYCLES),
      .T2_CYCLES(OCP_T2_CYCLES),
      .T3_CYCLES(OCP_T3_CYCLES)
   ) u_ocp (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .filterSel(st_r.ctrl.ocpFilter),
      .rawOver(st_r.ocpSync[1]),
      .tripped(overcurrentTrip)
   );

   assign regRdData = st_r.rdData;
   // detection only runs while a supply is present
   assign inputDetectReq = st_r.ctrl.forceDetect && vbusPresent;
   assign safetyTimerTick = st_r.safetyTick;
   assign batterySwitchOn = (st_r.swState != charger_regs_pkg::SW_OFF);
   assign warmVoltageClamp = st_r.clamp;
   assign switchResetEnable = st_r.ctrl.switchRstEn;
   assign overcurrentFilterSel = st_r.ctrl.ocpFilter;
   assign watchdogExpired = st_r.fault.wdFault;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence ship_request;
      st_r.swState == charger_regs_pkg::SW_ON && st_r.ctrl.switchOff;
   endsequence

   sequence switch_parked;
      st_r.swState != charger_regs_pkg::SW_ON && !st_r.ctrl.switchOff;
   endsequence

   a_detect_self_clear: assert property (st_r.ctrl.forceDetect && inputDetectDone && !ctrlWrite
      && !regDefaultsRestore |=> !st_r.ctrl.forceDetect)
      else $error("detect bit not cleared on completion");
   a_half_rate_skip: assert property (st_r.tick && slowTimer && !st_r.halfPhase
      |=> !safetyTimerTick ##[1:2] !safetyTimerTick)
      else $error("safety tick not halved");
   a_ship_immediate: assert property (ship_request and !st_r.ctrl.switchDelay
      |=> !batterySwitchOn)
      else $error("switch not off at once");
   a_ship_delayed: assert property (ship_request and st_r.ctrl.switchDelay
      |=> batterySwitchOn ##1 batterySwitchOn)
      else $error("switch turned off before delay");
   a_warm_clamp: assert property (tempZoneIn == charger_regs_pkg::ZONE_WARM
      && !st_r.ctrl.warmVoltSel && !ctrlWrite && !wdExpire && !regDefaultsRestore
      ##1 st_r.ctrl.warmVoltSel == 1'b0 |=> warmVoltageClamp)
      else $error("warm clamp missing");
   a_restore_all: assert property (regDefaultsRestore
      |=> st_r.ctrl == charger_regs_pkg::CTRL_RESET)
      else $error("defaults not restored");
   a_wd_partial: assert property (wdExpire && !regDefaultsRestore && !ctrlWrite
      |=> st_r.ctrl.switchOff == $past(st_r.ctrl.switchOff) && st_r.ctrl.halfRate
      && watchdogExpired)
      else $error("watchdog expiry restore wrong");
   a_status_ro: assert property (regWrEn && regAddr == charger_regs_pkg::STATUS_OFFSET
      |=> st_r.status.chargePhase == $past(chargePhaseIn)
      && st_r.status.powerGood == $past(powerGoodIn))
      else $error("status altered by write");
   a_zone_live: assert property (1'b1 |=> st_r.fault.tempZone == $past(tempZoneIn))
      else $error("zone code not live");
   a_wd_kick_clear: assert property ((watchdogKick || regDefaultsRestore) && !wdExpire
      |=> !watchdogExpired)
      else $error("watchdog flag not cleared");
   a_source_live: assert property (!BASE_VARIANT
      |=> st_r.status.sourceType == $past(detectedSourceType))
      else $error("source type not live");
   a_full_rate: assert property (st_r.tick && !slowTimer
      |=> safetyTimerTick)
      else $error("safety tick missing");
   a_switch_release: assert property (switch_parked
      |=> st_r.swState == charger_regs_pkg::SW_ON)
      else $error("switch not released");
   a_off_holds: assert property (st_r.swState == charger_regs_pkg::SW_OFF
      && st_r.ctrl.switchOff |=> !batterySwitchOn)
      else $error("switch left off state");
   a_clamp_off: assert property (st_r.ctrl.warmVoltSel
      |=> !warmVoltageClamp)
      else $error("clamp despite target select");
   a_fault_live: assert property (1'b1
      |=> st_r.fault.chargeFault == $past(chargeFaultIn))
      else $error("fault code not live");
   a_status_live: assert property (1'b1
      |=> st_r.status.thermReg == $past(thermRegActive))
      else $error("thermal flag not live");
endmodule

// *** dv/charger_core_model.sv ***
// charger core stand-in: runs input limit detection when asked
// assumes the register block holds its request as a level until done is seen
`timescale 1ns/1ps
module charger_core_model (
   input wire logic core_clk,
   input wire logic [7:0] doneDelay,
   input wire logic inputDetectReq,
   output logic inputDetectDone
);
   // ------------------------------
   // detection engine
   // ------------------------------
   // delay is set by the bench so both prompt and slow answers get exercised
   initial begin
      inputDetectDone = 1'b0;
      forever begin
         @(negedge core_clk);
         if (inputDetectReq) begin
            repeat (doneDelay) @(negedge core_clk);
            inputDetectDone = 1'b1;
            @(negedge core_clk);
            inputDetectDone = 1'b0;
         end
      end
   end
endmodule

// *** dv/test_charger_control_status_regs.sv ***
// bench for the charger control and status register group
// assumes short tick, deglitch, ship delay and watchdog parameters
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module test_charger_control_status_regs;
   logic core_clk = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, doneDelay = 8'h05;
   logic regDefaultsRestore = 1'b0, watchdogKick = 1'b0, vbusPresent = 1'b0;
   logic [1:0] watchdogPeriodSel = 2'h0, chargePhaseIn = 2'h0, chargeFaultIn = 2'h0;
   logic dpmActive = 1'b0, thermRegActive = 1'b0, sourceSelectPin = 1'b0, otgActive = 1'b0;
   logic [2:0] detectedSourceType = 3'h0, tempZoneIn = 3'h0;
   logic powerGoodIn = 1'b0, minSysRegIn = 1'b0, otgFaultIn = 1'b0, batFaultIn = 1'b0;
   logic overcurrentPin = 1'b0, inputDetectDone, inputDetectReq, safetyTimerTick;
   logic batterySwitchOn, warmVoltageClamp, switchResetEnable, overcurrentTrip;
   logic watchdogExpired;
   logic [1:0] overcurrentFilterSel;
   int errors = 0, samplesChecked = 0, cycles = 0, n;
   int win[4] = '{3, 5, 7, 9};
   logic [2:0] srcs[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
   logic [2:0] zones[7] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h0, 3'h2};

   charger_control_status_regs #(.BASE_VARIANT(1'b0), .TICK_CYCLES(4), .SHIP_DELAY_TICKS(5),
      .OCP_T0_CYCLES(3), .OCP_T1_CYCLES(5), .OCP_T2_CYCLES(7), .OCP_T3_CYCLES(9),
      .WD_40S_TICKS(6))
   u_charger_control_status_regs (.core_clk(core_clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .regDefaultsRestore(regDefaultsRestore),
      .watchdogKick(watchdogKick), .watchdogPeriodSel(watchdogPeriodSel),
      .vbusPresent(vbusPresent), .inputDetectDone(inputDetectDone), .dpmActive(dpmActive),
      .thermRegActive(thermRegActive), .sourceSelectPin(sourceSelectPin),
      .detectedSourceType(detectedSourceType), .otgActive(otgActive),
      .chargePhaseIn(chargePhaseIn), .powerGoodIn(powerGoodIn), .minSysRegIn(minSysRegIn),
      .otgFaultIn(otgFaultIn), .chargeFaultIn(chargeFaultIn), .batFaultIn(batFaultIn),
      .tempZoneIn(tempZoneIn), .overcurrentPin(overcurrentPin),
      .inputDetectReq(inputDetectReq), .safetyTimerTick(safetyTimerTick),
      .batterySwitchOn(batterySwitchOn), .warmVoltageClamp(warmVoltageClamp),
      .switchResetEnable(switchResetEnable), .overcurrentFilterSel(overcurrentFilterSel),
      .overcurrentTrip(overcurrentTrip), .watchdogExpired(watchdogExpired));

   charger_core_model u_charger_core_model (.core_clk(core_clk), .doneDelay(doneDelay),
      .inputDetectReq(inputDetectReq), .inputDetectDone(inputDetectDone));

   // ------------------------------
   // clock, timeout and closing
   // ------------------------------
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   // ceiling well above the roughly 600 cycles the tests need
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checked %0d mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------
   // register port tasks
   // ------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge core_clk);
      regRdEn = 1'b0;
      @(negedge core_clk);
      `CHK("read data", e, regRdData)
   endtask

   task automatic waitc(input int c);
      repeat (c) @(negedge core_clk);
   endtask

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      waitc(5);
      sys_rst = 1'b0;
      rd(8'h07, 8'h4C);
      `CHK("reset enable", 1'b1, switchResetEnable)
      `CHK("switch on", 1'b1, batterySwitchOn)
      rd(8'h0A, 8'h00);
      $display("reset values done");

      // status and fault fields track the live inputs, writes there do nothing
      for (int i = 0; i < 7; i++) begin
         detectedSourceType = srcs[i];
         chargePhaseIn = 2'(i);
         powerGoodIn = i[0];
         thermRegActive = i[1];
         minSysRegIn = i[2];
         otgActive = i[0];
         sourceSelectPin = i[2];
         otgFaultIn = ~i[0];
         chargeFaultIn = 2'(i + 1);
         batFaultIn = i[1];
         tempZoneIn = zones[i];
         waitc(2);
         rd(8'h08, {srcs[i], 2'(i), i[0], i[1], i[2]});
         rd(8'h09, {1'b0, ~i[0], 2'(i + 1), i[1], zones[i]});
         wr(8'h08, 8'hFF);
         wr(8'h09, 8'hFF);
         rd(8'h09, {1'b0, ~i[0], 2'(i + 1), i[1], zones[i]});
      end
      $display("status test done");

      thermRegActive = 1'b0;
      vbusPresent = 1'b1;
      wr(8'h07, 8'hC4);
      `CHK("detect request", 1'b1, inputDetectReq)
      waitc(12);
      rd(8'h07, 8'h44);
      doneDelay = 8'h00;
      wr(8'h07, 8'hC4);
      waitc(3);
      rd(8'h07, 8'h44);
      wr(8'h07, 8'h40);
      waitc(2);
      `CHK("reset enable", 1'b0, switchResetEnable)
      tempZoneIn = 3'h2;
      wr(8'h07, 8'h44);
      waitc(3);
      `CHK("warm clamp", 1'b1, warmVoltageClamp)
      wr(8'h07, 8'h54);
      waitc(3);
      `CHK("warm clamp", 1'b0, warmVoltageClamp)
      tempZoneIn = 3'h0;
      $display("control bits done");

      // half rate: 80 cycles hold 20 ticks at 4 cycles each
      for (int m = 0; m < 3; m++) begin
         wr(8'h07, m == 2 ? 8'h04 : 8'h44);
         dpmActive = (m != 1);
         waitc(8);
         n = 0;
         for (int c = 0; c < 80; c++) begin
            @(negedge core_clk);
            n += safetyTimerTick;
         end
         `CHK("tick count", m == 0 ? 10 : 20, n)
      end
      dpmActive = 1'b0;
      $display("safety timer done");

      for (int s = 0; s < 4; s++) begin
         wr(8'h44, 8'h00);
         wr(8'h07, 8'h44 | 8'(s));
         waitc(2);
         `CHK("filter select", 2'(s), overcurrentFilterSel)
         overcurrentPin = 1'b1;
         waitc(win[s] + 1);
         `CHK("early trip", 1'b0, overcurrentTrip)
         waitc(1);
         `CHK("trip", 1'b1, overcurrentTrip)
         overcurrentPin = 1'b0;
         waitc(4);
         `CHK("trip clear", 1'b0, overcurrentTrip)
      end
      $display("deglitch done");

      wr(8'h07, 8'h64);
      waitc(3);
      `CHK("switch off now", 1'b0, batterySwitchOn)
      wr(8'h07, 8'h44);
      waitc(2);
      `CHK("switch back", 1'b1, batterySwitchOn)
      wr(8'h07, 8'h6C);
      waitc(8);
      `CHK("switch waiting", 1'b1, batterySwitchOn)
      waitc(24);
      `CHK("switch late off", 1'b0, batterySwitchOn)
      @(negedge core_clk);
      regDefaultsRestore = 1'b1;
      @(negedge core_clk);
      regDefaultsRestore = 1'b0;
      rd(8'h07, 8'h4C);
      waitc(2);
      `CHK("switch restored", 1'b1, batterySwitchOn)
      $display("ship mode done");

      // expiry restores defaults except in the switch off, delay and filter fields and raises the flag
      watchdogPeriodSel = 2'h1;
      wr(8'h07, 8'h3B);
      waitc(40);
      `CHK("watchdog flag", 1'b1, watchdogExpired)
      rd(8'h07, 8'h6F);
      rd(8'h09, 8'hF8);
      watchdogPeriodSel = 2'h0;
      watchdogKick = 1'b1;
      waitc(1);
      watchdogKick = 1'b0;
      waitc(1);
      `CHK("watchdog clear", 1'b0, watchdogExpired)
      $display("watchdog done");
      stop_test();
   end
endmodule
